// ---- tccs_cfg.svh ----
// constants of the timer channel: register offsets, field positions,
// reset values and masks.
// assumes inclusion by bare name from the package and design modules.
`ifndef TCCS_CFG_SVH
`define TCCS_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define TCCS_OFS_CTRL 12'h000
`define TCCS_OFS_CMP 12'h004
`define TCCS_OFS_STAT 12'h008
`define TCCS_OFS_COUNT 12'h00C
`define TCCS_OFS_MASK 12'h010
`define TCCS_OFS_EXT_CTRL3 12'h034
`define TCCS_OFS_EXT_STAT3 12'h038

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TCCS_BIT_DBG_HOLD_DIS 31
`define TCCS_BIT_COUNT_EN 30
`define TCCS_BIT_INT_EN 29
`define TCCS_MODE_HI 28
`define TCCS_MODE_LO 27
`define TCCS_BIT_CLEAR 26
`define TCCS_BIT_ACTIVE 25
`define TCCS_BIT_EVENT_EN 24
`define TCCS_BIT_WAKE_EN 23
`define TCCS_BIT_LATCH_EN 16
`define TCCS_PRESCALE_HI 7
`define TCCS_PRESCALE_LO 0

// ----------------------------------------------------------------
// status register fields (also mask layout)
// ----------------------------------------------------------------
`define TCCS_BIT_MATCH 0
`define TCCS_BIT_WAKE 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TCCS_RST_CTRL 32'h0000_0005
`define TCCS_RST_ZERO 32'h0000_0000
`define TCCS_RST_MASK 2'h3

`endif

// ---- tccs_far_end.sv ----
// event pin source outside the timer.
// assumes one clock; pulses stay well below a third of its rate.
`timescale 1ns/10ps
module tccs_far_end #(parameter int PULSES = 6) (
  input wire logic clk_in,
  input wire logic go_in,
  output logic event_out = 1'b0,
  output logic busy_out = 1'b0
);
  int cnt = 0; // half periods left
  logic [1:0] ph = 2'h0; // cycles in a half period
  // three cycles a level keeps events at a sixth of the clock
  always @(posedge clk_in) begin
    if (go_in && !busy_out) begin
      busy_out <= 1'b1;
      cnt <= 2 * PULSES;
      ph <= 2'h0;
    end else if (busy_out) begin
      ph <= ph + 2'h1;
      if (ph == 2'h2) begin
        ph <= 2'h0;
        event_out <= ~event_out;
        cnt <= cnt - 1;
        if (cnt == 1) busy_out <= 1'b0;
      end
    end
  end
endmodule : tccs_far_end

// ---- tccs_pkg.sv ----
// types shared by the timer channel modules.
// assumes tccs_cfg.svh is on the include path.
`include "tccs_cfg.svh"

package tccs_pkg;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCCS_ONE_SHOT = 2'h0,
    TCCS_PERIODIC = 2'h1,
    TCCS_TOGGLE = 2'h2,
    TCCS_CONTINUOUS = 2'h3
  } tccs_mode_t;

  typedef logic [23:0] tccs_count_t; // up counter width

endpackage : tccs_pkg

// ---- tccs_prescaler.sv ----
// 8-bit prescale counter: one-cycle tick every (prescale+1) clocks.
// assumes the caller gates it with run and clears it with clear_in.
`timescale 1ns/10ps

module tccs_prescaler (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic [7:0] prescale_in,
  output logic tick_out
);

  logic [7:0] div_reg; // prescale counter

  // ----------------------------------------------------------------
  // divider; zero prescale gives a tick every running cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in || clear_in) begin
      div_reg <= 8'h00;
      tick_out <= 1'b0;
    end else if (run_in) begin
      if (div_reg >= prescale_in) begin
        div_reg <= 8'h00;
        tick_out <= 1'b1;
      end else begin
        div_reg <= div_reg + 8'h01;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0; // no tick while suspended; count held
    end
  end

endmodule : tccs_prescaler

// ---- tccs_sync.sv ----
// two flip-flop synchroniser for one level from outside the clock domain.
// assumes a single clock clk_in; reset clears both stages of the chain to zero.
`timescale 1ns/10ps

module tccs_sync (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg; // first stage, read only by the second

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : tccs_sync

// ---- tccs_timer.sv ----
// one general-purpose timer channel with an apb register slave.
// assumes apb master on clk_in; event, debug and unlock pins are async.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`include "tccs_cfg.svh"

module tccs_timer
  import tccs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic event_pin_in,
  input wire logic debug_halt_in,
  input wire logic reg_unlock_in,
  output logic toggle_out,
  output logic irq_out,
  output logic wake_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic dbg_hold_dis_reg; // debug hold disable
  logic count_en_reg; // count enable
  logic int_en_reg; // interrupt enable
  tccs_mode_t mode_reg; // operating mode
  logic event_en_reg; // event count enable
  logic wake_en_reg; // wake enable
  logic latch_en_reg; // data latch enable
  logic [7:0] prescale_reg; // prescale field
  tccs_count_t compare_reg; // compare value
  tccs_count_t counter_reg; // internal up counter
  tccs_count_t count_value_reg; // readable count register
  logic [1:0] status_reg; // sticky match and wake flags
  logic [1:0] mask_reg; // interrupt and wake output mask
  logic [31:0] ext_ctrl3_reg; // external control, storage only
  logic [31:0] ext_stat3_reg; // external status, storage only
  logic event_sync; // synchronised event pin
  logic event_prev_reg; // event pin last cycle
  logic halt_sync; // synchronised debugger halt
  logic unlock_sync; // synchronised unlock
  logic tick; // prescaled tick
  logic advance; // counter steps this cycle
  logic running; // counter may count
  logic match_hit; // counter reaches compare on a step
  logic wr_en; // apb write access phase
  logic rd_en; // apb read access phase
  logic clear_req; // counter clear taking effect
  logic cmp_wr; // compare register written
  logic [31:0] ctrl_rd; // control register read view

  // ----------------------------------------------------------------
  // apb decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] ofs);
    hit = (paddr_in == ofs);
  endfunction : hit

  // zero-wait slave: access phase always completes in one cycle
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && penable_in && !pwrite_in;
  // clear acts only while the counter is active
  assign clear_req = wr_en && hit(`TCCS_OFS_CTRL)
    && pwdata_in[`TCCS_BIT_CLEAR] && count_en_reg;
  assign cmp_wr = wr_en && hit(`TCCS_OFS_CMP);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  tccs_sync u_sync_event (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(event_pin_in),
    .sync_out(event_sync)
  );

  tccs_sync u_sync_halt (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(debug_halt_in),
    .sync_out(halt_sync)
  );

  tccs_sync u_sync_unlock (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(reg_unlock_in),
    .sync_out(unlock_sync)
  );

  // ----------------------------------------------------------------
  // counting engine
  // ----------------------------------------------------------------
  // debugger halt stops the prescaler and counter steps unless hold is disabled
  assign running = count_en_reg
    && (dbg_hold_dis_reg || !halt_sync);

  tccs_prescaler u_prescaler (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .clear_in(clear_req || (cmp_wr && mode_reg != TCCS_CONTINUOUS)),
    .run_in(running && !event_en_reg),
    .prescale_in(prescale_reg),
    .tick_out(tick)
  );

  // event mode counts rising pin edges instead of ticks
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      event_prev_reg <= 1'b0;
    end else begin
      event_prev_reg <= event_sync;
    end
  end

  assign advance = running && (event_en_reg
    ? (event_sync && !event_prev_reg) : tick);
  // match when the step lands on the compare value
  assign match_hit = advance
    && ((counter_reg + 24'h00_0001) == compare_reg);

  // up counter; wraps to zero on match except continuous mode
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      counter_reg <= 24'h00_0000;
    end else if (clear_req) begin
      counter_reg <= 24'h00_0000;
    end else if (cmp_wr && mode_reg != TCCS_CONTINUOUS) begin
      counter_reg <= 24'h00_0000;
    end else if (advance) begin
      if (match_hit && mode_reg != TCCS_CONTINUOUS) begin
        counter_reg <= 24'h00_0000;
      end else begin
        counter_reg <= counter_reg + 24'h00_0001;
      end
    end
  end

  // toggle output inverts on each match in toggle mode
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      toggle_out <= 1'b0;
    end else if (match_hit && mode_reg == TCCS_TOGGLE) begin
      toggle_out <= !toggle_out;
    end
  end

  // readable count register follows counter while active with latch enabled
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count_value_reg <= 24'h00_0000;
    end else if (latch_en_reg && count_en_reg) begin
      count_value_reg <= counter_reg;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dbg_hold_dis_reg <= 1'b0;
      int_en_reg <= 1'b0;
      mode_reg <= TCCS_ONE_SHOT;
      event_en_reg <= 1'b0;
      wake_en_reg <= 1'b0;
      latch_en_reg <= 1'b0;
      prescale_reg <= 8'(`TCCS_RST_CTRL); // low byte holds prescale
    end else if (wr_en && hit(`TCCS_OFS_CTRL)) begin
      if (unlock_sync) begin
        dbg_hold_dis_reg <= pwdata_in[`TCCS_BIT_DBG_HOLD_DIS];
      end
      int_en_reg <= pwdata_in[`TCCS_BIT_INT_EN];
      mode_reg <= tccs_mode_t'(pwdata_in[`TCCS_MODE_HI:`TCCS_MODE_LO]);
      event_en_reg <= pwdata_in[`TCCS_BIT_EVENT_EN];
      wake_en_reg <= pwdata_in[`TCCS_BIT_WAKE_EN];
      latch_en_reg <= pwdata_in[`TCCS_BIT_LATCH_EN];
      prescale_reg <= pwdata_in[`TCCS_PRESCALE_HI:`TCCS_PRESCALE_LO];
    end
  end

  // count enable: clear and one-shot match win over a write
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count_en_reg <= 1'b0;
    end else if (clear_req) begin
      count_en_reg <= 1'b0;
    end else if (match_hit && mode_reg == TCCS_ONE_SHOT) begin
      count_en_reg <= 1'b0;
    end else if (wr_en && hit(`TCCS_OFS_CTRL)) begin
      count_en_reg <= pwdata_in[`TCCS_BIT_COUNT_EN];
    end
  end

  // ----------------------------------------------------------------
  // compare, mask and storage-only registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      compare_reg <= 24'h00_0000;
      ext_ctrl3_reg <= `TCCS_RST_ZERO;
      mask_reg <= `TCCS_RST_MASK;
    end else if (wr_en) begin
      if (hit(`TCCS_OFS_CMP)) begin
        compare_reg <= pwdata_in[23:0];
      end
      if (hit(`TCCS_OFS_EXT_CTRL3)) begin
        ext_ctrl3_reg <= pwdata_in;
      end
      if (hit(`TCCS_OFS_MASK)) begin
        mask_reg <= pwdata_in[1:0];
      end
    end
  end

  // external status: write one clears, nothing sets it here
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ext_stat3_reg <= `TCCS_RST_ZERO;
    end else if (wr_en && hit(`TCCS_OFS_EXT_STAT3)) begin
      ext_stat3_reg <= ext_stat3_reg & ~pwdata_in;
    end
  end

  // ----------------------------------------------------------------
  // sticky status; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      status_reg <= 2'b00;
    end else begin
      if (match_hit) begin
        status_reg[`TCCS_BIT_MATCH] <= 1'b1;
      end else if (wr_en && hit(`TCCS_OFS_STAT)
          && pwdata_in[`TCCS_BIT_MATCH]) begin
        status_reg[`TCCS_BIT_MATCH] <= 1'b0;
      end
      if (match_hit && wake_en_reg) begin
        status_reg[`TCCS_BIT_WAKE] <= 1'b1;
      end else if (wr_en && hit(`TCCS_OFS_STAT)
          && pwdata_in[`TCCS_BIT_WAKE]) begin
        status_reg[`TCCS_BIT_WAKE] <= 1'b0;
      end
    end
  end

  // interrupt and wake outputs, registered
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      irq_out <= int_en_reg
        && status_reg[`TCCS_BIT_MATCH] && mask_reg[`TCCS_BIT_MATCH];
      wake_out <= status_reg[`TCCS_BIT_WAKE]
        && mask_reg[`TCCS_BIT_WAKE];
    end
  end

  // ----------------------------------------------------------------
  // apb read mux
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_rd = 32'h0000_0000; // reserved bits read zero
    ctrl_rd[`TCCS_BIT_DBG_HOLD_DIS] = dbg_hold_dis_reg;
    ctrl_rd[`TCCS_BIT_COUNT_EN] = count_en_reg;
    ctrl_rd[`TCCS_BIT_INT_EN] = int_en_reg;
    ctrl_rd[`TCCS_MODE_HI:`TCCS_MODE_LO] = mode_reg;
    ctrl_rd[`TCCS_BIT_ACTIVE] = count_en_reg;
    ctrl_rd[`TCCS_BIT_EVENT_EN] = event_en_reg;
    ctrl_rd[`TCCS_BIT_WAKE_EN] = wake_en_reg;
    ctrl_rd[`TCCS_BIT_LATCH_EN] = latch_en_reg;
    ctrl_rd[`TCCS_PRESCALE_HI:`TCCS_PRESCALE_LO] = prescale_reg;
  end

  // read data and error registered in the setup cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
      pready_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      if (psel_in && !penable_in) begin
        unique case (paddr_in)
          `TCCS_OFS_CTRL: prdata_out <= ctrl_rd;
          `TCCS_OFS_CMP: prdata_out <= {8'h00, compare_reg};
          `TCCS_OFS_STAT: prdata_out <= {30'h0, status_reg};
          `TCCS_OFS_COUNT: prdata_out <= {8'h00, count_value_reg};
          `TCCS_OFS_MASK: prdata_out <= {30'h0, mask_reg};
          `TCCS_OFS_EXT_CTRL3: prdata_out <= ext_ctrl3_reg;
          `TCCS_OFS_EXT_STAT3: prdata_out <= ext_stat3_reg;
          default: pslverr_out <= 1'b1; // unmapped address
        endcase
      end
    end
  end

  logic unused_rd; // read strobe kept for clarity of decode
  assign unused_rd = rd_en;

endmodule : tccs_timer

// ---- tccs_timer_properties.sv ----
// apb timing and output relations of the timer channel.
// assumes binding to tccs_timer, one clock, synchronous reset.
`timescale 1ns/10ps
`include "tccs_cfg.svh"
module tccs_timer_properties (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic toggle_out,
  input wire logic irq_out,
  input wire logic wake_out
);
  // --------------------------------
  // phases
  // --------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence setup_s;
    psel_in && !penable_in;
  endsequence
  sequence access_s;
    psel_in && penable_in;
  endsequence
  sequence wr_s(logic [11:0] a);
    psel_in && penable_in && pwrite_in && paddr_in == a;
  endsequence
  logic mapped; // address decodes to a register
  assign mapped = paddr_in inside {`TCCS_OFS_CTRL, `TCCS_OFS_CMP,
    `TCCS_OFS_STAT, `TCCS_OFS_COUNT, `TCCS_OFS_MASK,
    `TCCS_OFS_EXT_CTRL3, `TCCS_OFS_EXT_STAT3};
  // --------------------------------
  // properties
  // --------------------------------
  ready_after_setup_a: assert property (setup_s |=> pready_out)
    else $error("no ready after setup");
  ready_in_access_a: assert property (pready_out |-> access_s)
    else $error("ready outside access");
  ready_one_cycle_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than a cycle");
  err_unmapped_a: assert property (setup_s and !mapped |=> pslverr_out)
    else $error("no error on unmapped address");
  err_mapped_a: assert property (setup_s and mapped |=> !pslverr_out)
    else $error("error on mapped address");
  ctrl_reserved_a: assert property (
    pready_out && !pwrite_in && paddr_in == `TCCS_OFS_CTRL
    |-> prdata_out[22:17] == 6'h0 && prdata_out[15:8] == 8'h00)
    else $error("reserved control bits not zero");
  irq_gate_a: assert property (
    wr_s(`TCCS_OFS_CTRL) and !pwdata_in[29] |-> ##2 !irq_out)
    else $error("irq with interrupt disabled");
  mask_gate_a: assert property (
    wr_s(`TCCS_OFS_MASK) and pwdata_in[1:0] == 2'h0
    |-> ##2 !irq_out && !wake_out)
    else $error("masked event still signalled");
  flag_clear_a: assert property (
    wr_s(`TCCS_OFS_STAT) and pwdata_in[0] |-> ##2 !irq_out)
    else $error("irq stays after flag clear");
  reset_quiet_a: assert property (
    $fell(reset_in) |-> !irq_out && !wake_out && !toggle_out)
    else $error("outputs not quiet after reset");
endmodule : tccs_timer_properties

bind tccs_timer tccs_timer_properties u_props (.clk_in, .reset_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .pready_out, .pslverr_out, .toggle_out, .irq_out,
  .wake_out);

// ---- test_tccs_timer.sv ----
// self-checking bench for the timer channel over apb.
// assumes tccs_timer, its bound checker and the event source.
`timescale 1ns/10ps
`include "tccs_cfg.svh"
module test_tccs_timer;
  import tccs_pkg::*;
  // --------------------------------
  // signals
  // --------------------------------
  logic clk_in = 0, reset_in = 1, psel = 0, pen = 0, pwr = 0;
  logic halt = 0, unlock = 0, go = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v;
  logic pready, perr, tog, irq, wake, evt, busy;
  logic [32:0] eq[$], mq[$]; // expected {err,data} and masks
  int fail_count = 0, cmp_count = 0, cyc = 0, n, p, a;
  localparam logic [32:0] ALL = 33'h1_ffff_ffff;
  localparam logic [32:0] ERR = 33'h1_0000_0000;
  localparam logic [11:0] CT = `TCCS_OFS_CTRL, CP = `TCCS_OFS_CMP;
  localparam logic [11:0] ST = `TCCS_OFS_STAT, CN = `TCCS_OFS_COUNT;
  localparam logic [11:0] X3 = `TCCS_OFS_EXT_CTRL3;
  localparam logic [31:0] EN = 32'h4000_0000, IE = 32'h2000_0000;
  localparam logic [31:0] WK = 32'h0080_0000, LAT = 32'h0001_0000;
  localparam logic [31:0] PER = 32'h0800_0000 | LAT; // periodic
  tccs_timer DUT (.clk_in, .reset_in, .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .event_pin_in(evt), .debug_halt_in(halt),
    .reg_unlock_in(unlock), .toggle_out(tog), .irq_out(irq),
    .wake_out(wake));
  tccs_far_end far (.clk_in, .go_in(go), .event_out(evt),
    .busy_out(busy));
  initial forever #5 clk_in = ~clk_in;
  // --------------------------------
  // checking
  // --------------------------------
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic summarize();
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // oldest note is paired with each completed transfer
  always @(posedge clk_in) begin
    if (psel && pen && pready === 1'b1 && eq.size() > 0) begin
      chk({perr, prdata} & mq[0], eq[0] & mq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  // hang guard, far above the expected run
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  // --------------------------------
  // apb master
  // --------------------------------
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d, input logic [32:0] e, m);
    @(posedge clk_in);
    psel <= 1; pen <= 0; pwr <= w; paddr <= ad; pwdata <= d;
    eq.push_back(e);
    mq.push_back(m);
    @(posedge clk_in);
    pen <= 1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    pen <= 0;
  endtask : apb
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1, ad, d, 33'h0, ERR);
  endtask : wr
  task automatic rdx(input logic [11:0] ad, input logic [32:0] e, m);
    apb(0, ad, 32'h0, e, m);
  endtask : rdx
  task automatic wait_tog(output int k);
    logic t;
    t = tog;
    k = 0;
    do begin @(posedge clk_in); k++; end while (tog === t && k < 900);
  endtask : wait_tog
  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    void'($urandom(32'h0c1b_4056));
    repeat (10) @(posedge clk_in);
    reset_in <= 0;
    rdx(CT, 33'h5, ALL);
    rdx(CP, 0, ALL);
    rdx(ST, 0, ALL);
    rdx(CN, 0, ALL);
    rdx(`TCCS_OFS_MASK, 33'h3, ALL);
    rdx(`TCCS_OFS_EXT_STAT3, 0, ALL);
    rdx(12'h040, ERR, ERR);
    v = $urandom();
    wr(X3, v);
    rdx(X3, {1'b0, v}, ALL);
    p = $urandom_range(255);
    wr(CT, 32'hbfff_ff00 | p);
    rdx(CT, {1'b0, 32'h3981_0000 | p}, 33'h1_fbff_ffff);
    @(posedge clk_in);
    unlock <= 1;
    repeat (4) @(posedge clk_in);
    wr(CT, 32'h8000_0000);
    rdx(CT, 33'h0_8000_0000, 33'h1_fbff_ffff);
    wr(CT, 32'h0);
    @(posedge clk_in);
    unlock <= 0;
    // toggle period over two prescale settings
    for (p = 0; p < 4; p += 3) begin
      wr(CP, 32'h5);
      wr(CT, EN | 32'h1000_0000 | p);
      wait_tog(n);
      wait_tog(n);
      chk(33'(n), 33'((p + 1) * 5));
    end
    wr(CT, 32'h0);
    rdx(ST, 33'h1, ALL);
    wr(ST, 32'h3);
    // one-shot with interrupt and wake
    wr(CP, 32'h8);
    wr(CT, EN | IE | WK | LAT);
    for (a = 0; a < 100 && irq !== 1'b1; a++) @(posedge clk_in);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq, wake}, 33'h3);
    rdx(CT, {1'b0, IE | WK | LAT}, ALL);
    rdx(ST, 33'h3, ALL);
    wr(`TCCS_OFS_MASK, 32'h0);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq, wake}, 33'h0);
    wr(`TCCS_OFS_MASK, 32'h3);
    wr(ST, 32'h1);
    rdx(ST, 33'h2, ALL);
    wr(ST, 32'h2);
    // suspend, resume, debug hold, restart, clear
    wr(CT, PER);
    wr(CP, 32'h0010_0000);
    wr(CT, EN | PER);
    repeat (20) @(posedge clk_in);
    wr(CT, PER);
    rdx(CN, 0, ERR);
    v = rd;
    repeat (10) @(posedge clk_in);
    rdx(CN, {1'b0, v}, ALL);
    wr(CT, EN | PER);
    rdx(CN, 0, ERR);
    chk({32'h0, rd > v}, 33'h1);
    @(posedge clk_in);
    halt <= 1;
    repeat (4) @(posedge clk_in);
    rdx(CN, 0, ERR);
    v = rd;
    repeat (10) @(posedge clk_in);
    rdx(CN, {1'b0, v}, ALL);
    halt <= 0;
    wr(CP, 32'h0010_0000);
    rdx(CN, 0, ERR);
    chk({32'h0, rd < 10}, 33'h1);
    wr(CT, EN | PER | 32'h1000_0000);
    repeat (30) @(posedge clk_in);
    rdx(CN, 0, ERR);
    v = rd;
    wr(CP, 32'h0010_0000);
    rdx(CN, 0, ERR);
    chk({32'h0, rd > v}, 33'h1);
    wr(CT, EN | PER | 32'h1400_0000);
    rdx(CT, 0, 33'h0_4200_0000);
    wr(CT, EN | PER | 32'h1000_0000);
    rdx(CN, 0, ERR);
    chk({32'h0, rd < 10}, 33'h1);
    // pin events instead of clock ticks
    wr(CT, PER);
    wr(CP, 32'h1000);
    wr(CT, EN | PER | 32'h0100_0000);
    @(posedge clk_in);
    go <= 1;
    @(posedge clk_in);
    go <= 0;
    @(posedge clk_in);
    for (a = 0; a < 200 && busy === 1'b1; a++) @(posedge clk_in);
    repeat (6) @(posedge clk_in);
    rdx(CN, 33'h6, ALL);
    summarize();
  end
endmodule : test_tccs_timer
